// File: hw/selector_channel_dma_sequencer.sv
// Selector channel sequencer with programmed I/O path and Wishbone register slave.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
module selector_channel_dma_sequencer
  import sel_dma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output private_io_bus_out_t private_io_bus,
  input wire logic [15:0] private_data_in,
  input wire logic private_sync,
  input wire logic status_check_line,
  output logic [PIO_LINES-1:0] main_io_bus_lines,
  output logic [15:0] main_io_bus_data_out,
  output logic main_io_bus_data_oe,
  input wire logic [15:0] main_io_bus_data_in,
  input wire logic main_sync,
  output logic condition_multiplexer_sync,
  output logic memory_microinterrupt,
  output logic memory_read_dir,
  output logic [23:0] memory_address,
  output logic [15:0] memory_write_data,
  input wire logic [15:0] memory_read_data,
  input wire logic memory_done,
  input wire logic interrupt_mask_bit,
  output logic good_termination_flag,
  output logic bad_termination_flag,
  output logic service_pending_flag,
  output logic channel_busy
);

  seq_state_t state_q, state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic dir_read_q, half_q, hs_q;
  logic chan_sel_q;
  logic [23:0] start_q, addr_q, wcnt_q;
  logic carry_q;
  logic [15:0] xfer_q;
  logic status_bad_q;
  logic good_q, bad_q, service_q, masked_q;
  logic [PIO_LINES-1:0] pio_lines_q;
  logic [15:0] pio_data_q, pio_rd_q;
  logic pio_ack_q;

  logic req, wr_take;
  logic ctrl_wr, start_wr, final_wr, pio_ctrl_wr, pio_data_wr;
  logic idle;
  logic go, stop_cmd, bad_cmd;
  logic count_step;
  logic [24:0] wcnt_sum;
  logic [23:0] addr_next, final_val;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] lanes);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (lanes[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request; writes land at the acked edge.

  assign req = cyc_i && stb_i;
  assign wr_take = req && we_i && ack_q;
  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  always_comb
  begin
    ctrl_wr = 1'b0;
    start_wr = 1'b0;
    final_wr = 1'b0;
    pio_ctrl_wr = 1'b0;
    pio_data_wr = 1'b0;
    if (adr_i == CTRL_OFS)
    begin
      ctrl_wr = wr_take && sel_i[0];
    end
    else if (adr_i == START_OFS)
    begin
      start_wr = wr_take;
    end
    else if (adr_i == FINAL_OFS)
    begin
      final_wr = wr_take;
    end
    else if (adr_i == PIO_CTRL_OFS)
    begin
      pio_ctrl_wr = wr_take;
    end
    else if (adr_i == PIO_DATA_OFS)
    begin
      pio_data_wr = wr_take;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req && !ack_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (req && !ack_q)
    begin
      if (adr_i == START_OFS)
      begin
        rdata_q <= {8'h00, start_q};
      end
      else if (adr_i == STATUS_OFS)
      begin
        rdata_q <= {21'h000000, hs_q, half_q, dir_read_q, condition_multiplexer_sync, pio_ack_q,
                    carry_q, chan_sel_q, service_q, bad_q, good_q, channel_busy};
      end
      else if (adr_i == ADDR_OFS)
      begin
        rdata_q <= {8'h00, addr_q};
      end
      else if (adr_i == WCNT_OFS)
      begin
        rdata_q <= {8'h00, wcnt_q};
      end
      else if (adr_i == XFER_OFS)
      begin
        rdata_q <= {16'h0000, xfer_q};
      end
      else if (adr_i == PIO_CTRL_OFS)
      begin
        rdata_q <= {26'h0000000, pio_lines_q};
      end
      else if (adr_i == PIO_DATA_OFS)
      begin
        rdata_q <= {16'h0000, pio_rd_q};
      end
      else
      begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Commands and initialization.

  assign idle = (state_q == S_IDLE);
  assign channel_busy = !idle;
  assign go = ctrl_wr && dat_i[CTRL_GO_BIT] && idle && chan_sel_q;
  assign stop_cmd = ctrl_wr && dat_i[CTRL_STOP_BIT];
  assign bad_cmd = ctrl_wr && dat_i[CTRL_BAD_BIT];
  assign final_val = 24'(merge_lanes({8'h00, start_q}, dat_i, sel_i));

  // The address line written with the channel's own address arms initialization.
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      chan_sel_q <= 1'b0;
    end
    else if (state_q == S_WAIT)
    begin
      chan_sel_q <= 1'b0;
    end
    else if (pio_ctrl_wr && !dat_i[PIO_RST_BIT] && dat_i[PIO_ADDR_LINE] && idle)
    begin
      chan_sel_q <= (pio_data_q[7:0] == CHAN_DEV_ADDR);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      dir_read_q <= 1'b0;
      half_q <= 1'b0;
      hs_q <= 1'b0;
    end
    else if (go)
    begin
      dir_read_q <= dat_i[CTRL_READ_BIT];
      half_q <= dat_i[CTRL_HALF_BIT];
      hs_q <= dat_i[CTRL_HS_BIT];
    end
  end

  // One unit is counted as the last handshake of a transfer completes.
  assign count_step = (state_q == S_DATA_RST2) && !private_sync;
  assign wcnt_sum = {1'b0, wcnt_q} + 25'h0000001;
  assign addr_next = addr_q + 24'h000001;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      start_q <= COUNT_RESET;
      addr_q <= COUNT_RESET;
      wcnt_q <= COUNT_RESET;
      carry_q <= 1'b0;
    end
    else if (idle && chan_sel_q && start_wr)
    begin
      start_q <= 24'(merge_lanes({8'h00, start_q}, dat_i, sel_i));
      addr_q <= 24'(merge_lanes({8'h00, start_q}, dat_i, sel_i));
    end
    else if (idle && chan_sel_q && final_wr)
    begin
      wcnt_q <= start_q - final_val;
      carry_q <= 1'b0;
    end
    else if (count_step)
    begin
      wcnt_q <= wcnt_sum[23:0];
      addr_q <= addr_next;
      carry_q <= wcnt_sum[24];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer. The state register advances on every 100 ns clock edge.

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q <= S_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (go)
        begin
          if (!dat_i[CTRL_READ_BIT])
          begin
            state_d = S_MEM_INT;
          end
          else if (dat_i[CTRL_HS_BIT])
          begin
            state_d = S_DATA_REQ2;
          end
          else if (dat_i[CTRL_HALF_BIT])
          begin
            state_d = S_STAT_REQ2;
          end
          else
          begin
            state_d = S_STAT_REQ1;
          end
        end
      end
      S_MEM_INT: state_d = S_MEM_INT_CLR;
      S_MEM_INT_CLR:
      begin
        if (memory_done)
        begin
          if (carry_q)
          begin
            state_d = S_TRANSFER_END;
          end
          else if (hs_q)
          begin
            state_d = dir_read_q ? S_DATA_REQ2 : S_DATA_AVAIL2;
          end
          else
          begin
            state_d = half_q ? S_STAT_REQ2 : S_STAT_REQ1;
          end
        end
      end
      S_STAT_REQ1: state_d = private_sync ? S_STAT_RST1 : state_q;
      S_STAT_RST1:
      begin
        if (status_bad_q)
        begin
          state_d = S_BAD_STATUS;
        end
        else if (!private_sync)
        begin
          state_d = dir_read_q ? S_DATA_REQ1 : S_DATA_AVAIL1;
        end
      end
      S_DATA_AVAIL1, S_DATA_REQ1: state_d = private_sync ? S_DATA_RST1 : state_q;
      S_DATA_RST1: state_d = private_sync ? state_q : S_STAT_REQ2;
      S_STAT_REQ2: state_d = private_sync ? S_STAT_RST2 : state_q;
      S_STAT_RST2:
      begin
        if (status_bad_q)
        begin
          state_d = S_BAD_STATUS;
        end
        else if (!private_sync)
        begin
          state_d = dir_read_q ? S_DATA_REQ2 : S_DATA_AVAIL2;
        end
      end
      S_DATA_AVAIL2, S_DATA_REQ2:
      begin
        if (hs_q && status_check_line)
        begin
          state_d = S_BAD_STATUS;
        end
        else if (private_sync)
        begin
          state_d = S_DATA_RST2;
        end
      end
      S_DATA_RST2:
      begin
        if (count_step)
        begin
          state_d = (wcnt_sum[24] && !dir_read_q) ? S_TRANSFER_END : S_MEM_INT;
        end
      end
      S_BAD_STATUS, S_TRANSFER_END: state_d = S_HOLD1;
      S_HOLD1: state_d = S_HOLD2;
      S_HOLD2: state_d = S_HOLD1;
      S_WAIT: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
    // Outside idle and wait, stop outranks every other command; bad status only cuts an active transfer.
    if (stop_cmd && state_q != S_IDLE && state_q != S_WAIT)
    begin
      state_d = S_WAIT;
    end
    else if (bad_cmd && state_q inside {[S_MEM_INT:S_DATA_RST2]})
    begin
      state_d = S_BAD_STATUS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Termination flags, held until the channel is stopped.

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      good_q <= 1'b0;
      bad_q <= 1'b0;
      service_q <= 1'b0;
      masked_q <= 1'b0;
    end
    else if (state_q == S_WAIT)
    begin
      good_q <= 1'b0;
      bad_q <= 1'b0;
      service_q <= 1'b0;
      masked_q <= 1'b0;
    end
    else if (state_q == S_TRANSFER_END || state_q == S_BAD_STATUS)
    begin
      good_q <= good_q || (state_q == S_TRANSFER_END);
      bad_q <= bad_q || (state_q == S_BAD_STATUS);
      masked_q <= interrupt_mask_bit;
    end
    else if (state_q == S_HOLD2 && masked_q && !interrupt_mask_bit)
    begin
      service_q <= 1'b1;
      masked_q <= 1'b0;
    end
  end

  assign good_termination_flag = good_q;
  assign bad_termination_flag = bad_q || service_q;
  assign service_pending_flag = service_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer data: bytes pair high first, then low, into one halfword.

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      xfer_q <= DATA_RESET;
      status_bad_q <= 1'b0;
    end
    else
    begin
      if ((state_q == S_STAT_REQ1 || state_q == S_STAT_REQ2) && private_sync)
      begin
        status_bad_q <= |(private_data_in[7:0] & STATUS_BAD_MASK);
      end
      if (state_q == S_MEM_INT_CLR && memory_done && !dir_read_q)
      begin
        xfer_q <= memory_read_data;
      end
      else if (state_q == S_DATA_REQ1 && private_sync)
      begin
        xfer_q[15:8] <= private_data_in[7:0];
      end
      else if (state_q == S_DATA_REQ2 && private_sync)
      begin
        xfer_q <= half_q ? private_data_in : {xfer_q[15:8], private_data_in[7:0]};
      end
    end
  end

  assign memory_microinterrupt = (state_q == S_MEM_INT);
  assign memory_read_dir = !dir_read_q;
  assign memory_address = addr_q;
  assign memory_write_data = xfer_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Programmed I/O. Lines hold until a reset-command issued after acknowledge.

  assign condition_multiplexer_sync = main_sync || (idle && private_sync);

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pio_lines_q <= '0;
      pio_data_q <= DATA_RESET;
      pio_ack_q <= 1'b0;
      pio_rd_q <= DATA_RESET;
    end
    else
    begin
      if (pio_ctrl_wr && dat_i[PIO_RST_BIT] && pio_ack_q)
      begin
        pio_lines_q <= '0;
        pio_data_q <= DATA_RESET;
        pio_ack_q <= 1'b0;
      end
      else
      begin
        if (pio_ctrl_wr && !dat_i[PIO_RST_BIT])
        begin
          pio_lines_q <= pio_lines_q | dat_i[PIO_LINES-1:0];
        end
        if (pio_data_wr)
        begin
          pio_data_q <= 16'(merge_lanes({16'h0000, pio_data_q}, dat_i, sel_i));
        end
        if (condition_multiplexer_sync && |pio_lines_q)
        begin
          pio_ack_q <= 1'b1;
        end
      end
      if (main_sync)
      begin
        pio_rd_q <= main_io_bus_data_in;
      end
      else if (idle && private_sync)
      begin
        pio_rd_q <= private_data_in;
      end
    end
  end

  assign main_io_bus_lines = pio_lines_q;
  assign main_io_bus_data_out = pio_data_q;
  assign main_io_bus_data_oe = |(pio_lines_q & PIO_WRITE_LINES);

  ////////////////////////////////////////////////////////////////////////////////
  // Private bus drive. Busy cuts the programmed I/O mirror so the processor times out.

  always_comb
  begin
    private_io_bus = '0;
    private_io_bus.byte_count_indicator = 1'b1;
    {private_io_bus.op_code_hi, private_io_bus.op_code_lo} = OP_RESET;
    case (state_q)
      S_IDLE:
      begin
        private_io_bus.pio_lines = pio_lines_q;
        private_io_bus.data = pio_data_q;
        private_io_bus.data_oe = main_io_bus_data_oe;
      end
      S_STAT_REQ1, S_STAT_REQ2:
      begin
        private_io_bus.private_status_request = 1'b1;
        private_io_bus.byte_count_indicator = (state_q == S_STAT_REQ2);
        {private_io_bus.op_code_hi, private_io_bus.op_code_lo} = OP_STATUS_REQ;
      end
      S_DATA_AVAIL1, S_DATA_AVAIL2:
      begin
        private_io_bus.private_data_available = 1'b1;
        private_io_bus.byte_count_indicator = (state_q == S_DATA_AVAIL2);
        private_io_bus.data = (state_q == S_DATA_AVAIL1) ? {8'h00, xfer_q[15:8]} :
                              (half_q ? xfer_q : {8'h00, xfer_q[7:0]});
        private_io_bus.data_oe = 1'b1;
        {private_io_bus.op_code_hi, private_io_bus.op_code_lo} = OP_DATA_AVAIL;
      end
      S_DATA_REQ1, S_DATA_REQ2:
      begin
        private_io_bus.private_data_request = 1'b1;
        private_io_bus.byte_count_indicator = (state_q == S_DATA_REQ2);
        {private_io_bus.op_code_hi, private_io_bus.op_code_lo} = OP_DATA_REQ;
      end
      S_STAT_RST1, S_DATA_RST1:
      begin
        private_io_bus.byte_count_indicator = 1'b0;
      end
      default:
      begin
        private_io_bus.byte_count_indicator = 1'b1;
      end
    endcase
  end

endmodule

// File: include/sel_dma_pkg.sv
// Constants, types and register map of the selector channel sequencer.
// Notes on behaviour
// - System clear puts the sequencer in idle; idle leaves only for 01, 03, 09 or 0C.
// - Status request states raise the request; 03 marks first byte, 09 second or halfword.
// - States 04 and 0A drop the status request after acknowledge, then data or bad.
// - Data-available states raise the line and drive outgoing data onto the private bus.
// - Data-request states raise the line and latch bus data on acknowledge.
// - Reset states drop the data line after acknowledge; 08 goes to 09, 0D onward.
// - Bad-status command moves to 0E, which flags bad termination, then goes to 14.
// - State 0F flags good termination, then goes to 14.
// - Word counter carry-out triggers good termination toward macro-interrupt logic.
// - Bad status returned on a status request ends through bad termination.
// - Status-check line in high-speed transfers only means bad termination.
// - Stop moves any state but 00 or 10 to 10, which returns to 00.
// - Termination while interrupts are masked alternates hold states 14 and 15.
// - Re-enabled interrupts during hold raise the service-pending flag.
// - A busy channel isolates its private bus; processor accesses then time out.
// - Channel address F0 is recognised and starts initialization only while idle.
// - Initialization loads start address and negated block size into the counters.
// - Go read or write hands the private bus to the sequencer and sets busy.
// - Programmed I/O lines stay until a reset-command after acknowledge clears line and data.
// - Private acknowledge reaches the condition multiplexer only while idle.
// - While idle, programmed I/O writes drive the same lines on the private bus.
// - Programmed reads take main bus data if it acknowledged, else private data.
// - Two-bit code: both reset, high only data available, low only request, neither status.
// - The state register advances on every cycle of the 100 ns clock.
// - Busy is asserted in every state other than idle.
// - Memory microinterrupt requests a memory operation, with a direction signal.
package sel_dma_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  typedef enum logic [4:0] {
    S_IDLE, S_MEM_INT, S_MEM_INT_CLR, S_STAT_REQ1, S_STAT_RST1, S_DATA_AVAIL1, S_DATA_REQ1,
    S_DATA_RST1, S_STAT_REQ2, S_STAT_RST2, S_DATA_AVAIL2, S_DATA_REQ2, S_DATA_RST2,
    S_BAD_STATUS, S_TRANSFER_END, S_WAIT, S_HOLD1, S_HOLD2
  } seq_state_t;

  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] START_OFS = 8'h04;
  localparam logic [7:0] FINAL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam logic [7:0] ADDR_OFS = 8'h10;
  localparam logic [7:0] WCNT_OFS = 8'h14;
  localparam logic [7:0] XFER_OFS = 8'h18;
  localparam logic [7:0] PIO_CTRL_OFS = 8'h1C;
  localparam logic [7:0] PIO_DATA_OFS = 8'h20;

  // Control register bit positions (write-only command pulses).
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_READ_BIT = 1;
  localparam int unsigned CTRL_STOP_BIT = 2;
  localparam int unsigned CTRL_BAD_BIT = 3;
  localparam int unsigned CTRL_HALF_BIT = 4;
  localparam int unsigned CTRL_HS_BIT = 5;

  // Programmed I/O line positions; lines 0 to 2 are write-type and carry data.
  localparam int unsigned PIO_LINES = 6;
  localparam int unsigned PIO_ADDR_LINE = 0;
  localparam int unsigned PIO_RST_BIT = 8;
  localparam logic [PIO_LINES-1:0] PIO_WRITE_LINES = 6'h07;

  localparam logic [7:0] CHAN_DEV_ADDR = 8'hF0;
  localparam logic [7:0] STATUS_BAD_MASK = 8'hF0;

  localparam logic [1:0] OP_RESET = 2'h3;
  localparam logic [1:0] OP_DATA_AVAIL = 2'h2;
  localparam logic [1:0] OP_DATA_REQ = 2'h1;
  localparam logic [1:0] OP_STATUS_REQ = 2'h0;

  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  typedef struct packed {
    logic private_status_request;
    logic private_data_available;
    logic private_data_request;
    logic byte_count_indicator;
    logic op_code_hi;
    logic op_code_lo;
    logic [PIO_LINES-1:0] pio_lines;
    logic [15:0] data;
    logic data_oe;
  } private_io_bus_out_t;

endpackage

// File: sim/sel_dma_monitor.sv
// Port checker for the selector channel sequencer.
module sel_dma_monitor
  import sel_dma_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire private_io_bus_out_t private_io_bus,
  input wire logic private_sync,
  input wire logic main_sync,
  input wire logic [PIO_LINES-1:0] main_io_bus_lines,
  input wire logic condition_multiplexer_sync,
  input wire logic memory_microinterrupt,
  input wire logic good_termination_flag,
  input wire logic bad_termination_flag,
  input wire logic service_pending_flag,
  input wire logic interrupt_mask_bit,
  input wire logic channel_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] op;
  assign op = {private_io_bus.op_code_hi, private_io_bus.op_code_lo};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  idle_code_a: assert property (!channel_busy |-> op == OP_RESET)
    else $error("idle op code wrong");
  stat_code_a: assert property (private_io_bus.private_status_request |-> op == OP_STATUS_REQ)
    else $error("status request code wrong");
  stat_drop_a: assert property (private_io_bus.private_status_request && private_sync
    |=> !private_io_bus.private_status_request)
    else $error("status request held after ack");
  avail_drive_a: assert property (private_io_bus.private_data_available
    |-> op == OP_DATA_AVAIL && private_io_bus.data_oe)
    else $error("data available not driving");
  req_drop_a: assert property (private_io_bus.private_data_request && private_sync
    |-> op == OP_DATA_REQ ##1 !private_io_bus.private_data_request)
    else $error("data request wrong");
  cmux_gate_a: assert property (condition_multiplexer_sync
    == (main_sync || (!channel_busy && private_sync)))
    else $error("condition sync wrong");
  mint_pulse_a: assert property ($rose(memory_microinterrupt) |=> !memory_microinterrupt)
    else $error("microinterrupt too long");
  wb_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer wrong");
  flag_busy_a: assert property (good_termination_flag || bad_termination_flag |-> channel_busy)
    else $error("flag while idle");
  svc_bad_a: assert property ($rose(service_pending_flag)
    |-> bad_termination_flag && !$past(interrupt_mask_bit))
    else $error("service without flag");
  pio_mirror_a: assert property (!channel_busy |-> private_io_bus.pio_lines == main_io_bus_lines)
    else $error("private lines differ");
  cover property (memory_microinterrupt);
  cover property (good_termination_flag);
  cover property (service_pending_flag);
endmodule
bind selector_channel_dma_sequencer sel_dma_monitor mon (.core_clk(core_clk), .rst_b(rst_b), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .private_io_bus(private_io_bus), .private_sync(private_sync),
  .main_sync(main_sync), .main_io_bus_lines(main_io_bus_lines),
  .condition_multiplexer_sync(condition_multiplexer_sync), .memory_microinterrupt(memory_microinterrupt),
  .good_termination_flag(good_termination_flag), .bad_termination_flag(bad_termination_flag),
  .service_pending_flag(service_pending_flag), .interrupt_mask_bit(interrupt_mask_bit),
  .channel_busy(channel_busy));

// File: sim/io_dev_model.sv
// Behavioural device controller on the private bus.
module io_dev_model
  import sel_dma_pkg::*;
(
  input wire logic core_clk,
  input wire private_io_bus_out_t bus,
  input wire logic bad_mode,
  output logic private_sync,
  output logic [15:0] private_data_in = 16'h0000,
  output logic status_check_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  assign req = bus.private_status_request | bus.private_data_available | bus.private_data_request | (|bus.pio_lines);
  assign status_check_line = bad_mode & bus.private_data_request;
  // The answer trails the line by a cycle, so the sequencer always sees a real wait.
  always_ff @(posedge core_clk)
    private_sync <= req;
  // Outside a request the lines toggle, so a late latch picks up garbage.
  always_ff @(posedge core_clk)
    if (bus.private_status_request)
      private_data_in <= bad_mode ? 16'h00F0 : 16'h0000;
    else if (bus.private_data_request)
      private_data_in <= 16'hA5C3;
    else
      private_data_in <= ~private_data_in;
endmodule

// File: sim/selector_channel_dma_sequencer_tb.sv
// Self-checking bench for the selector channel sequencer.
module selector_channel_dma_sequencer_tb
  import sel_dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, bad_mode = 1'b0;
  logic main_sync = 1'b0, mask = 1'b0, done = 1'b1;
  logic [31:0] dat_o;
  logic ack_o, psync, schk, cmux, good, bad, svc, busy, mrd;
  logic [15:0] pdin, wdata;
  logic [PIO_LINES-1:0] mlines;
  private_io_bus_out_t pbus;
  int bad_count = 0, check_count = 0, cyc_n = 0;
  selector_channel_dma_sequencer uut (.core_clk(core_clk), .rst_b(rst_b), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .private_io_bus(pbus), .private_data_in(pdin), .private_sync(psync), .status_check_line(schk),
    .main_io_bus_lines(mlines), .main_io_bus_data_out(), .main_io_bus_data_oe(),
    .main_io_bus_data_in(16'h0000), .main_sync(main_sync), .condition_multiplexer_sync(cmux),
    .memory_microinterrupt(), .memory_read_dir(mrd), .memory_address(), .memory_write_data(wdata),
    .memory_read_data(16'h0000), .memory_done(done), .interrupt_mask_bit(mask),
    .good_termination_flag(good), .bad_termination_flag(bad), .service_pending_flag(svc),
    .channel_busy(busy));
  io_dev_model dev (.core_clk(core_clk), .bus(pbus), .bad_mode(bad_mode), .private_sync(psync),
    .private_data_in(pdin), .status_check_line(schk));
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic cycle; the extra edge at the end lets registered effects land.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge core_clk); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic wait_end();
    for (int i = 0; i < 300 && good !== 1'b1 && bad !== 1'b1; i++)
      @(posedge core_clk);
  endtask
  task automatic stop();
    wr(CTRL_OFS, 32'h00000004);
    wr(CTRL_OFS, 32'h00000004);
    chk("busy stop", {busy, good, bad, svc}, 4'h0);
  endtask
  task automatic t_arm();
    logic [31:0] q;
    wr(PIO_DATA_OFS, 32'h000000F0);
    wr(PIO_CTRL_OFS, 32'h00000001);
    chk("mirror", pbus.pio_lines, 6'h01);
    repeat (3) @(posedge core_clk);
    chk("cmux", cmux, 1'b1);
    wr(PIO_CTRL_OFS, 32'h00000100);
    chk("lines", mlines, 6'h00);
    wb(STATUS_OFS, 1'b0, 32'h0, q);
    chk("armed", q[4], 1'b1);
  endtask
  task automatic t_reset();
    chk("op idle", {pbus.op_code_hi, pbus.op_code_lo}, OP_RESET);
    wr(CTRL_OFS, 32'h00000013);
    chk("go unarmed", busy, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_good();
    logic [31:0] q;
    t_arm();
    wr(START_OFS, 32'h00000100);
    wr(FINAL_OFS, 32'h00000101);
    wb(WCNT_OFS, 1'b0, 32'h0, q);
    chk("wcnt", q, 32'h00FFFFFF);
    mask <= 1'b1;
    wr(CTRL_OFS, 32'h00000013);
    chk("busy", busy, 1'b1);
    wait_end();
    chk("good", {good, bad}, 2'h2);
    chk("word", wdata, 16'hA5C3);
    wb(ADDR_OFS, 1'b0, 32'h0, q);
    chk("addr", q, 32'h00000101);
    repeat (4) @(posedge core_clk);
    chk("held", svc, 1'b0);
    mask <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("service", {svc, bad}, 2'h3);
    stop();
    $display("test good done");
  endtask
  task automatic t_bad();
    t_arm();
    bad_mode <= 1'b1;
    wr(CTRL_OFS, 32'h00000013);
    wait_end();
    chk("bad status", {good, bad, svc}, 3'h2);
    stop();
    t_arm();
    wr(CTRL_OFS, 32'h00000023);
    wait_end();
    chk("check line", {good, bad}, 2'h1);
    bad_mode <= 1'b0;
    stop();
    $display("test bad done");
  endtask
  task automatic t_cmd();
    done <= 1'b0;
    t_arm();
    wr(CTRL_OFS, 32'h00000001);
    chk("mem dir", mrd, 1'b1);
    wr(CTRL_OFS, 32'h00000008);
    wait_end();
    chk("bad cmd", {good, bad}, 2'h1);
    done <= 1'b1;
    stop();
    $display("test cmd done");
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_good();
    t_bad();
    t_cmd();
    end_sim();
  end
endmodule
